/* File: hw/dadc_chan_flags.sv */
// per-converter ready and error flags, result holding and write gating
`default_nettype none
module dadc_chan_flags (
  input  wire logic                       core_clk_in,
  input  wire logic                       srst_in,
  input  wire logic                       ce_in,
  input  wire logic                       clr_rdy_in,
  input  wire logic                       clr_err_in,
  input  wire logic                       conv_evt_in,
  input  wire logic                       cal_evt_in,
  input  wire logic                       cal_fail_in,
  input  wire logic                       clamped_in,
  input  wire logic                       force_ones_in,
  input  wire logic [dadc_pkg::RES_W-1:0] result_in,
  output logic                            ready_out,
  output logic                            error_out,
  output logic      [dadc_pkg::RES_W-1:0] result_out,
  output logic                            result_valid_out,
  output logic                            cal_we_out
);
  import dadc_pkg::*;

  logic             ready_reg;
  logic             error_reg;
  logic [RES_W-1:0] result_reg;
  logic             valid_reg;
  logic             cal_we_reg;
  logic             conv_wr;
  logic             cal_wr;

  assign conv_wr = conv_evt_in && !ready_reg;
  assign cal_wr  = cal_evt_in && !ready_reg && !cal_fail_in;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ready_reg <= 1'b0;
    end else if (ce_in) begin
      if (conv_evt_in || cal_evt_in) begin
        ready_reg <= 1'b1;
      end else if (clr_rdy_in) begin
        ready_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      error_reg <= 1'b0;
    end else if (ce_in) begin
      if (conv_wr && (clamped_in || force_ones_in)) begin
        error_reg <= 1'b1;
      end else if (cal_evt_in && cal_fail_in) begin
        error_reg <= 1'b1;
      end else if (clr_err_in) begin
        error_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      result_reg <= RES_RST;
      valid_reg  <= 1'b0;
      cal_we_reg <= 1'b0;
    end else if (ce_in) begin
      valid_reg  <= conv_wr;
      cal_we_reg <= cal_wr;
      if (conv_wr) begin
        result_reg <= force_ones_in ? RES_ONES : result_in;
      end
    end
  end

  assign ready_out        = ready_reg;
  assign error_out        = error_reg;
  assign result_out       = result_reg;
  assign result_valid_out = valid_reg;
  assign cal_we_out       = cal_we_reg;
endmodule
`default_nettype wire

/* File: hw/dadc_mode_status.sv */
// mode and status registers for the two sigma-delta converters
//
// Summary of operation
// - primary ready set on conversion/calibration end
// - primary ready cleared by software or restart
// - ready set blocks further result writes
// - auxiliary ready behaves like primary ready
// - calibration-done set when calibration finishes
// - calibration-done cleared only by mode start
// - missing reference checked only while a converter runs (enabled, mode not power-down)
// - missing external reference forces all ones
// - valid reference clears missing-reference flag
// - primary error set on clamped result
// - primary error set on failed calibration
// - primary error cleared by mode start
// - auxiliary error behaves like primary error
// - primary enable runs selected mode
// - primary enable low powers primary down
// - auxiliary enable runs selected mode
// - auxiliary enable low powers auxiliary down
// - three-bit mode field shared by converters
// - status at d8, reset 00, bit access
// - mode at d1, reset 00, byte only
// - mode field encodings, power-down default
// - single conversion returns mode to power-down
// - any mode field write resets both
// - calibration clears ready, returns to power-down
`default_nettype none
module dadc_mode_status (
  input  wire logic                                core_clk_in,
  input  wire logic                                srst_in,
  input  wire logic                                ce_in,
  input  wire logic [7:0]                          sfr_addr_in,
  input  wire logic [7:0]                          sfr_wdata_in,
  input  wire logic                                sfr_wr_in,
  output logic      [7:0]                          sfr_rdata_out,
  input  wire logic [7:0]                          bit_addr_in,
  input  wire logic                                bit_wdata_in,
  input  wire logic                                bit_wr_in,
  output logic                                     bit_rdata_out,
  input  wire logic [dadc_pkg::NUM_CONV-1:0]       conv_done_in,
  input  wire logic [dadc_pkg::NUM_CONV-1:0]       cal_done_in,
  input  wire logic [dadc_pkg::NUM_CONV-1:0]       cal_fail_in,
  input  wire logic [dadc_pkg::NUM_CONV-1:0]       clamped_in,
  input  wire logic [dadc_pkg::NUM_CONV*16-1:0]    result_in,
  input  wire logic [dadc_pkg::NUM_CONV-1:0]       ext_ref_sel_in,
  input  wire logic                                ref_fault_in,
  output logic      [dadc_pkg::NUM_CONV-1:0]       conv_run_out,
  output logic      [dadc_pkg::NUM_CONV-1:0]       conv_pdown_out,
  output logic      [dadc_pkg::NUM_CONV-1:0]       conv_reset_out,
  output logic      [2:0]                          mode_sel_out,
  output logic      [dadc_pkg::NUM_CONV*16-1:0]    result_out,
  output logic      [dadc_pkg::NUM_CONV-1:0]       result_valid_out,
  output logic      [dadc_pkg::NUM_CONV-1:0]       cal_we_out
);
  import dadc_pkg::*;

  // mode register fields
  logic       pen_reg;
  logic       aen_reg;
  dadc_mode_t md_reg;
  dadc_mode_t md_wr_val;

  // shared status flags
  logic       cal_flag_reg;
  logic       missing_ref;

  // per-converter views
  logic [NUM_CONV-1:0] en;
  logic [NUM_CONV-1:0] en_new;
  logic [NUM_CONV-1:0] ready;
  logic [NUM_CONV-1:0] error;
  logic [NUM_CONV-1:0] conv_evt;
  logic [NUM_CONV-1:0] cal_evt;
  logic [NUM_CONV-1:0] clr_rdy;
  logic [NUM_CONV-1:0] sw_clr_rdy;
  logic [NUM_CONV-1:0] force_ones;
  logic [NUM_CONV-1:0] pend_reg;
  logic [NUM_CONV-1:0] pend_left;
  logic [NUM_CONV-1:0] rst_req;
  logic [NUM_CONV-1:0] reset_reg;

  // decode
  logic       mode_wr;
  logic       stat_wr;
  logic       stat_bit_hit;
  logic       stat_bit_wr;
  logic [BITSEL_W-1:0] bit_sel;
  logic       starts_work;
  logic       one_shot_new;
  logic       md_is_conv;
  logic       md_is_cal;
  logic       md_one_shot;
  logic       any_active;
  logic       auto_pdown;
  logic [7:0] stat_byte;
  logic [7:0] mode_byte;
  logic [7:0] rdata_reg;
  logic       bit_rdata_reg;

  // address decoding
  always_comb begin
    mode_wr = 1'b0;
    stat_wr = 1'b0;
    if (sfr_wr_in && sfr_addr_in == MODE_ADDR) begin
      mode_wr = 1'b1;
    end else if (sfr_wr_in && sfr_addr_in == STAT_ADDR) begin
      stat_wr = 1'b1;
    end
  end

  // status bits sit at bit addresses d8..df
  assign stat_bit_hit = bit_addr_in[7:BITSEL_W] == STAT_ADDR[7:BITSEL_W];
  assign bit_sel      = bit_addr_in[BITSEL_W-1:0];
  assign stat_bit_wr  = bit_wr_in && stat_bit_hit;

  // value written into the mode field
  assign md_wr_val = dadc_mode_t'(sfr_wdata_in[MODE_MD_LSB +: MODE_MD_W]);
  assign en_new[CH_PRI] = sfr_wdata_in[MODE_PEN_BIT];
  assign en_new[CH_AUX] = sfr_wdata_in[MODE_AEN_BIT];

  // a write that starts a conversion or a calibration
  assign starts_work = mode_wr && md_wr_val != MD_PDOWN
                       && md_wr_val != MD_IDLE;
  assign one_shot_new = md_wr_val == MD_SINGLE || md_wr_val[2];

  // current mode classes
  assign md_is_conv  = md_reg == MD_SINGLE || md_reg == MD_CONT;
  assign md_is_cal   = md_reg[2];
  assign md_one_shot = md_reg == MD_SINGLE || md_is_cal;

  assign en[CH_PRI] = pen_reg;
  assign en[CH_AUX] = aen_reg;

  // mode register: byte access only
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pen_reg <= MODE_RST[MODE_PEN_BIT];
      aen_reg <= MODE_RST[MODE_AEN_BIT];
    end else if (ce_in && mode_wr) begin
      pen_reg <= en_new[CH_PRI];
      aen_reg <= en_new[CH_AUX];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      md_reg <= dadc_mode_t'(MODE_RST[MODE_MD_LSB +: MODE_MD_W]);
    end else if (ce_in) begin
      if (mode_wr) begin
        md_reg <= md_wr_val;
      end else if (auto_pdown) begin
        md_reg <= MD_PDOWN;
      end
    end
  end

  // converters still owing a result in a one-shot mode
  assign pend_left  = pend_reg & ~(conv_evt | cal_evt);
  assign auto_pdown = md_one_shot && pend_reg != CH_NONE
                      && pend_left == CH_NONE;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pend_reg <= CH_NONE;
    end else if (ce_in) begin
      if (mode_wr) begin
        pend_reg <= one_shot_new ? en_new : CH_NONE;
      end else begin
        pend_reg <= pend_left;
      end
    end
  end

  // reset requests; every mode write resets both converters,
  // whether the primary or the auxiliary enable rises or neither
  always_comb begin
    rst_req = CH_NONE;
    if (mode_wr) begin
      rst_req = ~CH_NONE;
      if (!pen_reg && en_new[CH_PRI]) begin
        rst_req = ~CH_NONE;
      end else if (!aen_reg && en_new[CH_AUX]) begin
        rst_req[CH_AUX] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      reset_reg <= CH_NONE;
    end else if (ce_in) begin
      reset_reg <= rst_req;
    end
  end

  // completion events; dropped during a mode write since the
  // converters are held in reset in the cycle after it
  assign conv_evt = conv_done_in & en & {NUM_CONV{md_is_conv && !mode_wr}};
  assign cal_evt  = cal_done_in & en & {NUM_CONV{md_is_cal && !mode_wr}};

  // software clear of ready: write zero by byte or by bit
  always_comb begin
    sw_clr_rdy = CH_NONE;
    if (stat_wr) begin
      sw_clr_rdy[CH_PRI] = !sfr_wdata_in[STAT_PRDY_BIT];
      sw_clr_rdy[CH_AUX] = !sfr_wdata_in[STAT_ARDY_BIT];
    end else if (stat_bit_wr && !bit_wdata_in) begin
      sw_clr_rdy[CH_PRI] = bit_sel == BITSEL_W'(STAT_PRDY_BIT);
      sw_clr_rdy[CH_AUX] = bit_sel == BITSEL_W'(STAT_ARDY_BIT);
    end
  end

  assign clr_rdy = sw_clr_rdy | {NUM_CONV{starts_work}};

  // converter is active when enabled and not powered down
  assign any_active = |conv_run_out;
  assign force_ones = ext_ref_sel_in & {NUM_CONV{missing_ref}};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CONV; gi++) begin : g_chan
      dadc_chan_flags u_flags (
        .core_clk_in      (core_clk_in),
        .srst_in          (srst_in),
        .ce_in            (ce_in),
        .clr_rdy_in       (clr_rdy[gi]),
        .clr_err_in       (starts_work),
        .conv_evt_in      (conv_evt[gi]),
        .cal_evt_in       (cal_evt[gi]),
        .cal_fail_in      (cal_fail_in[gi]),
        .clamped_in       (clamped_in[gi]),
        .force_ones_in    (force_ones[gi]),
        .result_in        (result_in[gi*RES_W +: RES_W]),
        .ready_out        (ready[gi]),
        .error_out        (error[gi]),
        .result_out       (result_out[gi*RES_W +: RES_W]),
        .result_valid_out (result_valid_out[gi]),
        .cal_we_out       (cal_we_out[gi])
      );
      assign conv_run_out[gi]   = en[gi] && md_reg != MD_PDOWN;
      assign conv_pdown_out[gi] = !conv_run_out[gi];
    end
  endgenerate

  dadc_ref_watch u_ref (
    .core_clk_in     (core_clk_in),
    .srst_in         (srst_in),
    .ce_in           (ce_in),
    .active_in       (any_active),
    .ref_fault_in    (ref_fault_in),
    .missing_ref_out (missing_ref)
  );

  // calibration-done: hardware set wins over the start clear
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cal_flag_reg <= STAT_RST[STAT_CAL_BIT];
    end else if (ce_in) begin
      if (|cal_evt) begin
        cal_flag_reg <= 1'b1;
      end else if (starts_work) begin
        cal_flag_reg <= 1'b0;
      end
    end
  end

  // readback images; reserved bits stay zero
  always_comb begin
    stat_byte = STAT_RST;
    stat_byte[STAT_PRDY_BIT]  = ready[CH_PRI];
    stat_byte[STAT_ARDY_BIT]  = ready[CH_AUX];
    stat_byte[STAT_CAL_BIT]   = cal_flag_reg;
    stat_byte[STAT_NOREF_BIT] = missing_ref;
    stat_byte[STAT_PERR_BIT]  = error[CH_PRI];
    stat_byte[STAT_AERR_BIT]  = error[CH_AUX];
  end

  always_comb begin
    mode_byte = MODE_RST;
    mode_byte[MODE_PEN_BIT] = pen_reg;
    mode_byte[MODE_AEN_BIT] = aen_reg;
    mode_byte[MODE_MD_LSB +: MODE_MD_W] = md_reg;
  end

  // registered read data, one cycle behind the address
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rdata_reg <= RD_UNMAPPED;
    end else if (ce_in) begin
      if (sfr_addr_in == STAT_ADDR) begin
        rdata_reg <= stat_byte;
      end else if (sfr_addr_in == MODE_ADDR) begin
        rdata_reg <= mode_byte;
      end else begin
        rdata_reg <= RD_UNMAPPED;
      end
    end
  end

  // bit reads reach only the status register
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      bit_rdata_reg <= 1'b0;
    end else if (ce_in) begin
      bit_rdata_reg <= stat_bit_hit && stat_byte[bit_sel];
    end
  end

  assign sfr_rdata_out  = rdata_reg;
  assign bit_rdata_out  = bit_rdata_reg;
  assign conv_reset_out = reset_reg;
  assign mode_sel_out   = md_reg;
endmodule
`default_nettype wire

/* File: hw/dadc_ref_watch.sv */
// missing-reference flag, sampled only while a converter runs
`default_nettype none
module dadc_ref_watch (
  input  wire logic core_clk_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  input  wire logic active_in,
  input  wire logic ref_fault_in,
  output logic      missing_ref_out
);
  import dadc_pkg::*;

  logic flag_reg;

  // flag holds its last verdict while both converters are down
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      flag_reg <= STAT_RST[STAT_NOREF_BIT];
    end else if (ce_in && active_in) begin
      flag_reg <= ref_fault_in;
    end
  end

  assign missing_ref_out = flag_reg;
endmodule
`default_nettype wire

/* File: inc/dadc_pkg.sv */
// package: register map, field positions and mode encodings
`default_nettype none
package dadc_pkg;
  localparam logic [7:0]  MODE_ADDR      = 8'hd1;
  localparam logic [7:0]  STAT_ADDR      = 8'hd8;
  localparam logic [7:0]  MODE_RST       = 8'h00;
  localparam logic [7:0]  STAT_RST       = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED    = 8'h00;
  localparam int          MODE_PEN_BIT   = 5;
  localparam int          MODE_AEN_BIT   = 4;
  localparam int          MODE_MD_LSB    = 0;
  localparam int          MODE_MD_W      = 3;
  localparam int          STAT_PRDY_BIT  = 7;
  localparam int          STAT_ARDY_BIT  = 6;
  localparam int          STAT_CAL_BIT   = 5;
  localparam int          STAT_NOREF_BIT = 4;
  localparam int          STAT_PERR_BIT  = 3;
  localparam int          STAT_AERR_BIT  = 2;
  localparam int          BITSEL_W       = 3;
  localparam int          NUM_CONV       = 2;
  localparam int          CH_PRI         = 0;
  localparam int          CH_AUX         = 1;
  localparam int          RES_W          = 16;
  localparam logic [15:0] RES_ONES       = 16'hffff;
  localparam logic [15:0] RES_RST        = 16'h0000;
  localparam logic [1:0]  CH_NONE        = 2'h0;

  typedef enum logic [2:0] {
    MD_PDOWN   = 3'h0,
    MD_IDLE    = 3'h1,
    MD_SINGLE  = 3'h2,
    MD_CONT    = 3'h3,
    MD_INT_ZS  = 3'h4,
    MD_INT_FS  = 3'h5,
    MD_SYS_ZS  = 3'h6,
    MD_SYS_FS  = 3'h7
  } dadc_mode_t;
endpackage
`default_nettype wire

/* File: testbench/dadc_mode_status_sva.sv */
// checker: timing relations at the mode/status block ports
`default_nettype none
module dadc_mode_status_sva
  import dadc_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       srst_in,
  input wire logic       ce_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic       sfr_wr_in,
  input wire logic [1:0] conv_done_in,
  input wire logic [1:0] cal_done_in,
  input wire logic [1:0] cal_fail_in,
  input wire logic [1:0] conv_run_out,
  input wire logic [1:0] conv_pdown_out,
  input wire logic [1:0] conv_reset_out,
  input wire logic [2:0] mode_sel_out,
  input wire logic [1:0] result_valid_out,
  input wire logic [1:0] cal_we_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_mode_wr;
    ce_in && sfr_wr_in && sfr_addr_in == MODE_ADDR;
  endsequence
  // only one converter enabled, so its completion ends the single run
  sequence s_single_done;
    ce_in && !sfr_wr_in && mode_sel_out == MD_SINGLE && conv_run_out == 2'b01 && conv_done_in[0];
  endsequence
  sequence s_cal_done;
    ce_in && !sfr_wr_in && mode_sel_out[2] && conv_run_out == 2'b11 && cal_done_in == 2'b11;
  endsequence
  a_mode_wr_reset: assert property (s_mode_wr |=> conv_reset_out == 2'b11)
    else $error("mode write did not reset both converters");
  a_mode_field: assert property (s_mode_wr |=> mode_sel_out == $past(sfr_wdata_in[2:0]))
    else $error("mode field not taken from write");
  a_pdown_inverse: assert property (conv_pdown_out == ~conv_run_out)
    else $error("power-down not inverse of run");
  a_run_needs_mode: assert property (|conv_run_out |-> mode_sel_out != MD_PDOWN)
    else $error("converter runs in power-down mode");
  a_single_return: assert property (s_single_done |=> mode_sel_out == MD_PDOWN)
    else $error("single conversion did not return to power-down");
  a_cal_return: assert property (s_cal_done |=> mode_sel_out == MD_PDOWN)
    else $error("calibration did not return to power-down");
  // a frozen enable stretches the pulses, so only an enabled edge is judged
  a_valid_cause: assert property (result_valid_out[0] && $past(ce_in)
    |-> $past(conv_done_in[0]))
    else $error("primary result update without completion");
  a_valid_once: assert property (result_valid_out[0] && ce_in |=> !result_valid_out[0])
    else $error("primary result written while ready set");
  a_aux_valid: assert property (result_valid_out[1] && $past(ce_in)
    |-> $past(conv_done_in[1]))
    else $error("aux result update without completion");
  a_cal_we_ok: assert property (cal_we_out[0] && $past(ce_in)
    |-> $past(cal_done_in[0]) && !$past(cal_fail_in[0]))
    else $error("calibration write after failed calibration");
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// testbench: register, conversion, calibration and reference checks
`default_nettype none
module testbench import dadc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_in = 0, srst_in = 1, ce_in = 1, sfr_wr_in = 0;
  logic        bit_wdata_in = 0, bit_wr_in = 0, ref_fault_in = 0, bit_rdata_out;
  logic [7:0]  sfr_addr_in = 0, sfr_wdata_in = 0, bit_addr_in = 0, sfr_rdata_out, en;
  logic [1:0]  conv_done_in = 0, cal_done_in = 0, cal_fail_in = 0, clamped_in = 0;
  logic [1:0]  ext_ref_sel_in = 0, conv_run_out, conv_pdown_out, conv_reset_out;
  logic [1:0]  result_valid_out, cal_we_out;
  logic [31:0] result_in = 0, result_out;
  logic [2:0]  mode_sel_out;
  logic [15:0] r;
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  dadc_mode_status uut (.core_clk_in, .srst_in, .ce_in, .sfr_addr_in, .sfr_wdata_in,
    .sfr_wr_in, .sfr_rdata_out, .bit_addr_in, .bit_wdata_in, .bit_wr_in, .bit_rdata_out,
    .conv_done_in, .cal_done_in, .cal_fail_in, .clamped_in, .result_in, .ext_ref_sel_in,
    .ref_fault_in, .conv_run_out, .conv_pdown_out, .conv_reset_out, .mode_sel_out,
    .result_out, .result_valid_out, .cal_we_out);
  always #5 core_clk_in = ~core_clk_in;
  task test_done();
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far above the fewer than one hundred cycles the sequence needs
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  task chk(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // expected status image of converter i from its ready and error flags
  function automatic logic [7:0] stat_exp(int i, logic rdy, logic err);
    stat_exp = STAT_RST;
    stat_exp[STAT_PRDY_BIT - i] = rdy;
    stat_exp[STAT_PERR_BIT - i] = err;
  endfunction
  task tick(int n = 1);
    repeat (n) @(negedge core_clk_in);
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1;
    tick();
    sfr_wr_in = 0;
  endtask
  task rd(logic [7:0] a, logic [7:0] exp, string name);
    sfr_addr_in = a;
    tick();
    chk(name, sfr_rdata_out, exp);
  endtask
  task bitw(logic [7:0] a, logic v);
    bit_addr_in = a;
    bit_wdata_in = v;
    bit_wr_in = 1;
    tick();
    bit_wr_in = 0;
  endtask
  task done(int i, logic [15:0] res, logic clamp);
    result_in[16*i+:16] = res;
    clamped_in[i] = clamp;
    conv_done_in[i] = 1;
    tick();
    conv_done_in = 0;
    clamped_in = 0;
  endtask
  initial begin
    void'($urandom(32'h09d0e686));
    tick(3);
    srst_in = 0;
    chk("pdown", conv_pdown_out, 2'b11);
    rd(STAT_ADDR, STAT_RST, "stat rst");
    rd(MODE_ADDR, MODE_RST, "mode rst");
    rd(8'hd2, RD_UNMAPPED, "unmapped");
    wr(MODE_ADDR, 8'hff);
    chk("reset pulse", conv_reset_out, 2'b11);
    rd(MODE_ADDR, 8'h37, "mode rsvd");
    wr(STAT_ADDR, 8'hff);
    rd(STAT_ADDR, 8'h00, "stat ro");
    for (int m = 0; m < 8; m++) begin
      wr(MODE_ADDR, 8'h20 | m[7:0]);
      chk("run", conv_run_out, {1'b0, m != 0});
      chk("mode", mode_sel_out, m);
      // free edge so the next write does not re-raise the strobe at once
      tick();
    end
    wr(MODE_ADDR, 8'h03);
    chk("disabled", conv_run_out, 2'b00);
    tick();
    for (int i = 0; i < 2; i++) begin
      en = i ? 8'h10 : 8'h20;
      wr(MODE_ADDR, en | MD_SINGLE);
      // headroom keeps the offsets below from wrapping
      r = 16'($urandom_range(0, 32'hfff0));
      done(i, r, 0);
      chk("single res", result_out[16*i+:16], r);
      chk("valid", result_valid_out, 2'b01 << i);
      chk("single ret", mode_sel_out, MD_PDOWN);
      rd(STAT_ADDR, stat_exp(i, 1'b1, 1'b0), "ready");
      wr(MODE_ADDR, en | MD_CONT);
      rd(STAT_ADDR, 8'h00, "restart clr");
      done(i, r + 16'h1, 1);
      rd(STAT_ADDR, stat_exp(i, 1'b1, 1'b1), "clamp err");
      done(i, r + 16'h2, 0);
      chk("blocked", result_out[16*i+:16], r + 16'h1);
      bitw(8'hdf - 8'(i), 0);
      bit_addr_in = 8'hdb - 8'(i);
      tick();
      chk("err bit", bit_rdata_out, 1'b1);
      done(i, r + 16'h3, 0);
      chk("after clr", result_out[16*i+:16], r + 16'h3);
      wr(MODE_ADDR, en | MD_CONT);
      rd(STAT_ADDR, 8'h00, "err clr");
    end
    for (int m = 4; m < 8; m++) begin
      wr(MODE_ADDR, 8'h30 | m[7:0]);
      cal_fail_in = 2'b10;
      cal_done_in = 2'b11;
      tick();
      cal_done_in = 0;
      chk("cal we", cal_we_out, 2'b01);
      cal_fail_in = 0;
      rd(STAT_ADDR, 8'he4, "cal stat");
      rd(MODE_ADDR, 8'h30, "cal ret");
    end
    wr(MODE_ADDR, 8'h33);
    rd(STAT_ADDR, 8'h00, "cal clr");
    ext_ref_sel_in = 2'b01;
    ref_fault_in = 1;
    tick(2);
    done(0, 16'h1234, 0);
    chk("forced", result_out[15:0], RES_ONES);
    rd(STAT_ADDR, 8'h98, "noref");
    ref_fault_in = 0;
    tick(2);
    rd(STAT_ADDR, 8'h88, "ref ok");
    wr(MODE_ADDR, 8'h00);
    ref_fault_in = 1;
    tick(2);
    rd(STAT_ADDR, 8'h88, "idle noref");
    // reset while powered down must drop the flags still standing
    srst_in = 1;
    tick();
    srst_in = 0;
    rd(STAT_ADDR, STAT_RST, "stat rerst");
    ce_in = 0;
    wr(MODE_ADDR, 8'h22);
    ce_in = 1;
    rd(MODE_ADDR, 8'h00, "frozen");
    test_done();
  end
endmodule
bind dadc_mode_status dadc_mode_status_sva u_sva (.core_clk_in, .srst_in, .ce_in,
  .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .conv_done_in, .cal_done_in, .cal_fail_in,
  .conv_run_out, .conv_pdown_out, .conv_reset_out, .mode_sel_out, .result_valid_out,
  .cal_we_out);
`default_nettype wire
